// File: nvg_pkg.sv
/*
  nvg_pkg: shared constants, field layouts and types of the nonvolatile
  write guard (register indices, bit positions, reset values, timing).
  assumes a 40 mhz system clock and a 32-bit classic wishbone register bus.
*/
package nvg_pkg;

  // timing: system clock and power-up hold-off
  localparam int unsigned NVG_CLK_HZ = 40_000_000;
  localparam int unsigned NVG_HOLDOFF_MS = 72;
  // least time, so round up to whole cycles
  localparam int unsigned NVG_HOLDOFF_CYC =
    32'((64'(NVG_HOLDOFF_MS) * 64'(NVG_CLK_HZ) + 64'd999) / 64'd1000);

  // bus geometry: byte address is four times the register index
  localparam int NVG_ADR_W = 12;
  localparam int NVG_IDX_W = 10;

  // register indices
  localparam logic [9:0] NVG_IDX_IRQ_FLAGS2 = 10'h00D;
  localparam logic [9:0] NVG_IDX_IRQ_EN2 = 10'h08D;
  localparam logic [9:0] NVG_IDX_DATA_LO = 10'h10C;
  localparam logic [9:0] NVG_IDX_ADDR_LO = 10'h10D;
  localparam logic [9:0] NVG_IDX_DATA_HI = 10'h10E;
  localparam logic [9:0] NVG_IDX_ADDR_HI = 10'h10F;
  localparam logic [9:0] NVG_IDX_CTRL = 10'h18C;
  localparam logic [9:0] NVG_IDX_UNLOCK = 10'h18D;

  // control register bit positions
  localparam int NVG_CTL_RD = 0;
  localparam int NVG_CTL_WR = 1;
  localparam int NVG_CTL_PERMIT = 2;
  localparam int NVG_CTL_FAULT = 3;
  localparam int NVG_CTL_ERASE = 4;
  localparam int NVG_CTL_SPACE = 7;

  // interrupt flag / enable bit position
  localparam int NVG_IRQ_DONE_BIT = 4;

  // unlock keys
  localparam logic [7:0] NVG_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVG_KEY_SECOND = 8'hAA;

  // values after power-on reset
  localparam logic [7:0] NVG_DATA_RST = 8'h00;
  localparam logic [1:0] NVG_HOLDOFF_CNT_RST = 2'h0;

  // self-write region limits, words below the limit are protected, for 00 words up to and including it
  localparam logic [10:0] NVG_WRT_LIMIT_10 = 11'h200;
  localparam logic [10:0] NVG_WRT_LIMIT_01 = 11'h400;
  localparam logic [10:0] NVG_WRT_LIMIT_00 = 11'h7FF;

  // control register fields
  typedef struct packed {
    logic space_sel;
    logic erase_sel;
    logic fault;
    logic permit;
    logic wr_start;
    logic rd_start;
  } nvg_ctrl_t;

  // command to the memory array
  typedef struct packed {
    logic req;
    logic we;
    logic erase;
    logic space;
    logic [10:0] addr;
    logic [13:0] wdata;
  } nvg_mem_cmd_t;

  // external programming interface pins
  typedef struct packed {
    logic req;
    logic we;
    logic space;
  } nvg_ext_t;

  // unlock sequence detector
  typedef enum logic [1:0] {
    NVG_UNL_IDLE = 2'b00,
    NVG_UNL_GOT55 = 2'b01,
    NVG_UNL_ARMED = 2'b10
  } nvg_unl_t;

  // true when a program-memory self-write to addr is inhibited
  function automatic logic nvg_region_blocked(input logic [1:0] wrt, input logic [10:0] addr);
    logic blk;
    blk = 1'b0;
    case (wrt)
      2'b11: blk = 1'b0;
      2'b10: blk = (addr < NVG_WRT_LIMIT_10);
      2'b01: blk = (addr < NVG_WRT_LIMIT_01);
      default: blk = (addr <= NVG_WRT_LIMIT_00);
    endcase
    return blk;
  endfunction : nvg_region_blocked

endpackage : nvg_pkg

// File: nvg_holdoff.sv
/*
  nvg_holdoff: power-up hold-off timer; active from power-on reset until
  the programmed number of system clock cycles has elapsed.
  assumes resetn_i is the power-on reset only.
*/
`timescale 1ns/1ps
module nvg_holdoff #(
  parameter int unsigned CYCLES = nvg_pkg::NVG_HOLDOFF_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // status
  output logic active_o
);
  import nvg_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r; // cycles elapsed since release
  logic active_r; // hold-off still running
  logic last; // final cycle of the hold-off

  assign last = (cnt_r == CW'(CYCLES - 1));
  assign active_o = active_r;

  // count up once after power-on, then stop
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= CW'(NVG_HOLDOFF_CNT_RST);
      active_r <= 1'b1;
    end else if (active_r) begin
      cnt_r <= cnt_r + 1'b1;
      active_r <= ~last;
    end
  end

endmodule : nvg_holdoff

// File: nvg_guard.sv
/*
  nvg_guard: register file and write guard of the nonvolatile memories.
  holds data, address and control registers, the unlock detector, the
  power-up hold-off, code-protection gating of the external programming
  port and the completion interrupt.
  assumes a classic wishbone master on the system clock, a memory array
  that answers each command with a one-cycle mem_done_i, configuration
  bits that are static after power-on, and a same-clock warm reset.
*/
`timescale 1ns/1ps
module nvg_guard #(
  parameter int unsigned HOLDOFF_CYC = nvg_pkg::NVG_HOLDOFF_CYC
) (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic warm_reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nvg_pkg::NVG_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // configuration word
  input wire logic cfg_data_protect_i,
  input wire logic cfg_prog_protect_i,
  input wire logic [1:0] cfg_wrt_region_i,
  // memory array
  output nvg_pkg::nvg_mem_cmd_t mem_cmd_o,
  input wire logic mem_done_i,
  input wire logic [13:0] mem_rdata_i,
  // external programming port
  input wire nvg_pkg::nvg_ext_t ext_pins_i,
  output logic ext_grant_o,
  output logic ext_deny_o,
  // status
  output logic holdoff_active_o
);
  import nvg_pkg::*;

  // registers
  logic [7:0] data_lo_r; // low data byte
  logic [5:0] data_hi_r; // high data bits, program words only
  logic [7:0] addr_lo_r; // low address byte
  logic [2:0] addr_hi_r; // high address bits
  nvg_ctrl_t ctrl_r; // control register
  nvg_ctrl_t ctrl_nxt;
  logic done_flag_r; // write operation complete, sticky
  logic done_flag_nxt;
  logic irq_en_r; // completion interrupt enable
  logic irq_r; // interrupt output flop
  nvg_unl_t unl_r; // unlock detector state
  nvg_unl_t unl_nxt;
  nvg_mem_cmd_t mem_cmd_r; // command held toward the array
  nvg_mem_cmd_t mem_cmd_nxt;
  nvg_mem_cmd_t mem_held; // command with request updated
  nvg_mem_cmd_t mem_new; // command launched this cycle
  logic ack_r; // bus acknowledge
  logic [31:0] dat_r; // bus read data

  // external port synchroniser and gating
  nvg_ext_t ext_s1_r;
  nvg_ext_t ext_s2_r;
  nvg_ext_t ext_s3_r;
  nvg_ext_t ext_q_r; // filtered external request
  logic ext_grant_r;
  logic ext_deny_r;
  logic ext_blocked; // request refused by code protection

  // decode
  logic [NVG_IDX_W-1:0] idx; // register index
  logic wb_hit; // new bus request this cycle
  logic bus_wr; // byte lane 0 write
  logic [7:0] wdat; // written byte
  logic [7:0] rd_byte; // selected read byte
  logic [7:0] ctrl_byte;
  logic [7:0] flags_byte;
  logic [7:0] en_byte;
  logic wr_ctrl;
  logic wr_unlock;
  logic wr_flags;
  logic wr_en;
  logic op_busy; // array operation in progress
  logic mem_done; // completion of an own operation
  logic rd_load; // read data returns
  logic wr_ask; // software asks for a write
  logic region_ok;
  logic holdoff_ok;
  logic holdoff_active;
  logic start_wr;
  logic start_rd;
  logic start_any;
  logic done_clr;

  // power-up hold-off timer
  nvg_holdoff #(
    .CYCLES(HOLDOFF_CYC)
  ) u_holdoff (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .active_o(holdoff_active)
  );

  // bus decode
  assign idx = wb_adr_i[NVG_ADR_W-1:2];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr = wb_hit & wb_we_i & wb_sel_i[0] & ~warm_reset_i;
  assign wdat = wb_dat_i[7:0];
  assign wr_ctrl = bus_wr & (idx == NVG_IDX_CTRL);
  assign wr_unlock = bus_wr & (idx == NVG_IDX_UNLOCK);
  assign wr_flags = bus_wr & (idx == NVG_IDX_IRQ_FLAGS2);
  assign wr_en = bus_wr & (idx == NVG_IDX_IRQ_EN2);

  // read selection; unimplemented bits and the unlock port read zero
  assign ctrl_byte = {ctrl_r.space_sel, 2'b00, ctrl_r.erase_sel, ctrl_r.fault,
                      ctrl_r.permit, ctrl_r.wr_start, ctrl_r.rd_start};
  assign flags_byte = 8'(done_flag_r) << NVG_IRQ_DONE_BIT;
  assign en_byte = 8'(irq_en_r) << NVG_IRQ_DONE_BIT;
  assign rd_byte = (idx == NVG_IDX_IRQ_FLAGS2) ? flags_byte :
                   (idx == NVG_IDX_IRQ_EN2) ? en_byte :
                   (idx == NVG_IDX_DATA_LO) ? data_lo_r :
                   (idx == NVG_IDX_ADDR_LO) ? addr_lo_r :
                   (idx == NVG_IDX_DATA_HI) ? {2'b00, data_hi_r} :
                   (idx == NVG_IDX_ADDR_HI) ? {5'b00000, addr_hi_r} :
                   (idx == NVG_IDX_CTRL) ? ctrl_byte :
                   8'h00;

  // launch decisions; own accesses are never gated by code protection
  assign op_busy = mem_cmd_r.req;
  assign mem_done = mem_done_i & mem_cmd_r.req;
  assign rd_load = mem_done & ~mem_cmd_r.we;
  assign wr_ask = wr_ctrl & wdat[NVG_CTL_WR] & ~op_busy;
  assign region_ok = ~wdat[NVG_CTL_SPACE] |
                     ~nvg_region_blocked(cfg_wrt_region_i, {addr_hi_r, addr_lo_r});
  assign holdoff_ok = wdat[NVG_CTL_SPACE] | ~holdoff_active;
  // permit must already be stored and the unlock keys just written
  assign start_wr = wr_ask & ctrl_r.permit & (unl_r == NVG_UNL_ARMED) &
                    region_ok & holdoff_ok;
  assign start_rd = wr_ctrl & wdat[NVG_CTL_RD] & ~op_busy & ~start_wr;
  assign start_any = start_wr | start_rd;

  // control register next value
  assign ctrl_nxt = warm_reset_i ?
    nvg_ctrl_t'{space_sel: ctrl_r.space_sel, erase_sel: 1'b0,
      fault: ctrl_r.fault | (op_busy & mem_cmd_r.we),
      permit: 1'b0, wr_start: 1'b0, rd_start: 1'b0} :
    nvg_ctrl_t'{space_sel: wr_ctrl ? wdat[NVG_CTL_SPACE] : ctrl_r.space_sel,
      erase_sel: wr_ctrl ? wdat[NVG_CTL_ERASE] : ctrl_r.erase_sel,
      fault: wr_ctrl ? wdat[NVG_CTL_FAULT] : ctrl_r.fault,
      permit: wr_ctrl ? wdat[NVG_CTL_PERMIT] : ctrl_r.permit,
      wr_start: start_wr | (ctrl_r.wr_start & ~mem_done),
      rd_start: start_rd | (ctrl_r.rd_start & ~mem_done)};

  // memory command: captured at launch, request dropped on done or abort
  assign mem_new = '{req: 1'b1, we: start_wr,
                     erase: start_wr & wdat[NVG_CTL_ERASE],
                     space: wdat[NVG_CTL_SPACE],
                     addr: {addr_hi_r, addr_lo_r},
                     wdata: {data_hi_r, data_lo_r}};
  always_comb begin
    mem_held = mem_cmd_r;
    mem_held.req = mem_cmd_r.req & ~mem_done & ~warm_reset_i;
  end
  assign mem_cmd_nxt = start_any ? mem_new : mem_held;

  // completion flag: hardware set wins over a write-one clear
  assign done_clr = wr_flags & wdat[NVG_IRQ_DONE_BIT];
  assign done_flag_nxt = ~warm_reset_i &
                         ((mem_done & mem_cmd_r.we) | (done_flag_r & ~done_clr));

  // unlock detector: only the key writes advance it, nothing is stored
  always_comb begin
    unl_nxt = unl_r;
    if (warm_reset_i) begin
      unl_nxt = NVG_UNL_IDLE;
    end else if (wr_unlock) begin
      case (unl_r)
        NVG_UNL_GOT55: begin
          if (wdat == NVG_KEY_SECOND) begin
            unl_nxt = NVG_UNL_ARMED;
          end else if (wdat == NVG_KEY_FIRST) begin
            unl_nxt = NVG_UNL_GOT55;
          end else begin
            unl_nxt = NVG_UNL_IDLE;
          end
        end
        default: begin
          unl_nxt = (wdat == NVG_KEY_FIRST) ? NVG_UNL_GOT55 : NVG_UNL_IDLE;
        end
      endcase
    end else if (bus_wr) begin
      // any other write, the control write included, ends the sequence
      unl_nxt = NVG_UNL_IDLE;
    end
  end

  // external port: a request is refused under code protection
  assign ext_blocked = (~ext_q_r.space & cfg_data_protect_i) |
                       (ext_q_r.space & ext_q_r.we & cfg_data_protect_i) |
                       (ext_q_r.space & cfg_prog_protect_i);

  // outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;
  assign mem_cmd_o = mem_cmd_r;
  assign ext_grant_o = ext_grant_r;
  assign ext_deny_o = ext_deny_r;
  assign holdoff_active_o = holdoff_active;

  // bus answer: one cycle after the request
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit & ~wb_we_i) begin
        dat_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // data and address: kept over a warm reset, data also loaded by reads
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_lo_r <= NVG_DATA_RST;
      data_hi_r <= NVG_DATA_RST[5:0];
      addr_lo_r <= NVG_DATA_RST;
      addr_hi_r <= NVG_DATA_RST[2:0];
    end else begin
      if (bus_wr & (idx == NVG_IDX_DATA_LO)) begin
        data_lo_r <= wdat;
      end else if (rd_load) begin
        data_lo_r <= mem_rdata_i[7:0];
      end
      if (bus_wr & (idx == NVG_IDX_DATA_HI)) begin
        data_hi_r <= wdat[5:0];
      end else if (rd_load & mem_cmd_r.space) begin
        data_hi_r <= mem_rdata_i[13:8];
      end
      if (bus_wr & (idx == NVG_IDX_ADDR_LO)) begin
        addr_lo_r <= wdat;
      end
      if (bus_wr & (idx == NVG_IDX_ADDR_HI)) begin
        addr_hi_r <= wdat[2:0];
      end
    end
  end

  // control, unlock, command and interrupt state
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= '0;
      unl_r <= NVG_UNL_IDLE;
      mem_cmd_r <= '0;
      done_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      unl_r <= unl_nxt;
      mem_cmd_r <= mem_cmd_nxt;
      done_flag_r <= done_flag_nxt;
      irq_en_r <= ~warm_reset_i & (wr_en ? wdat[NVG_IRQ_DONE_BIT] : irq_en_r);
      irq_r <= done_flag_r & irq_en_r;
    end
  end

  // external pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
      ext_q_r <= '0;
      ext_grant_r <= 1'b0;
      ext_deny_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_pins_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_q_r <= ext_s3_r;
      end
      ext_grant_r <= ext_q_r.req & ~ext_blocked;
      ext_deny_r <= ext_q_r.req & ext_blocked;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  AST_WARM_PERMIT: assert property (
    warm_reset_i |=> !ctrl_r.permit && !mem_cmd_r.req)
    else $error("permit or request survived a warm reset");
  AST_HOLDOFF: assert property (
    $rose(mem_cmd_r.req) && mem_cmd_r.we && !mem_cmd_r.space |-> !$past(holdoff_active))
    else $error("data write launched during hold-off");
  AST_UNLOCK: assert property (
    $rose(mem_cmd_r.req) && mem_cmd_r.we |->
      $past(unl_r) == NVG_UNL_ARMED && $past(ctrl_r.permit))
    else $error("write launched without unlock or permit");
  AST_OWN_DATA: assert property (
    wr_ctrl && wdat[NVG_CTL_WR] && !wdat[NVG_CTL_SPACE] && !op_busy && ctrl_r.permit &&
      unl_r == NVG_UNL_ARMED && !holdoff_active |=> mem_cmd_r.req && mem_cmd_r.we)
    else $error("own data write refused");
  AST_EXT_DATA: assert property (
    ext_q_r.req && !ext_q_r.space && cfg_data_protect_i |=> ext_deny_o && !ext_grant_o)
    else $error("external data access granted under protection");
  AST_EXT_PROG_WR: assert property (
    ext_q_r.req && ext_q_r.space && ext_q_r.we && cfg_data_protect_i |=> !ext_grant_o)
    else $error("external program write granted under data protection");
  AST_OWN_PROG_RD: assert property (
    wr_ctrl && wdat[NVG_CTL_RD] && !wdat[NVG_CTL_WR] && wdat[NVG_CTL_SPACE] && !op_busy |=>
      mem_cmd_r.req && !mem_cmd_r.we && mem_cmd_r.space)
    else $error("own program read not launched");
  AST_REGION: assert property (
    $rose(mem_cmd_r.req) && mem_cmd_r.we && mem_cmd_r.space |->
      !nvg_region_blocked($past(cfg_wrt_region_i), mem_cmd_r.addr))
    else $error("self-write into protected region");
  AST_EXT_PROG: assert property (
    ext_q_r.req && ext_q_r.space && cfg_prog_protect_i |=> ext_deny_o && !ext_grant_o)
    else $error("external program access granted under protection");
  AST_UNLOCK_READ: assert property (
    wb_hit && !wb_we_i && idx == NVG_IDX_UNLOCK |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("unlock port returned data");
  AST_WARM_KEEP: assert property (
    warm_reset_i && !rd_load |=> $stable(data_lo_r) && $stable(data_hi_r) &&
      $stable(addr_lo_r) && $stable(addr_hi_r))
    else $error("data or address changed at warm reset");
  AST_DONE_IRQ: assert property (
    mem_done && mem_cmd_r.we && irq_en_r && !warm_reset_i && !wr_en |=> done_flag_r ##1 irq_o)
    else $error("completion did not raise the interrupt");
  AST_FAULT: assert property (
    warm_reset_i && mem_cmd_r.req && mem_cmd_r.we |=> ctrl_r.fault)
    else $error("aborted write left no fault flag");

endmodule : nvg_guard

// File: test_nv_memory_write_guard.sv
/*
  test_nv_memory_write_guard: self-checking bench of nvg_guard.
  assumes nvg_pkg is compiled first; the bench drives every port itself,
  stands in for the memory array and the external programming pins.
*/
`timescale 1ns/1ps
module test_nv_memory_write_guard;
  import nvg_pkg::*;
  localparam int unsigned HOLD = 60; // shortened hold-off count
  // clock, resets and bus
  logic clk_sys_i, resetn_i, warm_reset_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [NVG_ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, irq_o;
  // configuration, array and external pins
  logic cfg_dp, cfg_pp;
  logic [1:0] cfg_wrt;
  nvg_mem_cmd_t mem_cmd;
  logic mem_done;
  logic [13:0] mem_rdata, md;
  nvg_ext_t ext_pins;
  logic ext_grant, ext_deny, holdoff_act;
  // bookkeeping
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hF2DF;
  string name_q[$];
  logic [31:0] exp_q[$];
  logic [9:0] ridx[4];
  logic [7:0] rmsk[4];
  logic [7:0] rval[4];

  nvg_guard #(.HOLDOFF_CYC(HOLD)) DUT (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .warm_reset_i(warm_reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .cfg_data_protect_i(cfg_dp), .cfg_prog_protect_i(cfg_pp),
    .cfg_wrt_region_i(cfg_wrt), .mem_cmd_o(mem_cmd), .mem_done_i(mem_done),
    .mem_rdata_i(mem_rdata), .ext_pins_i(ext_pins), .ext_grant_o(ext_grant),
    .ext_deny_o(ext_deny), .holdoff_active_o(holdoff_act));

  // free-running system clock, 25 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // pseudo-random source, shift register stepped on each call
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // compare and count, report at once on a mismatch
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // read results are matched against the oldest note when ack appears
  always @(posedge clk_sys_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), wb_dat_o);
    end
  end

  // one classic wishbone cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      chk("bus ack", 32'h1, 32'h0);
      complete_run();
    end
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  // note the expected byte, then read
  task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] e);
    name_q.push_back(nm);
    exp_q.push_back({24'h000000, e});
    xfer(1'b0, idx, 8'h00);
  endtask : rd

  // two-key unlock, sent just before the start write
  task automatic unl();
    wr(NVG_IDX_UNLOCK, NVG_KEY_FIRST);
    wr(NVG_IDX_UNLOCK, NVG_KEY_SECOND);
  endtask : unl

  // let c edges pass, then sample at the falling edge
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : settle

  // array answers the pending command with a one-cycle done
  task automatic done_pulse(input logic [13:0] d);
    @(posedge clk_sys_i);
    mem_done <= 1'b1;
    mem_rdata <= d;
    @(posedge clk_sys_i);
    mem_done <= 1'b0;
    mem_rdata <= ~d;
  endtask : done_pulse

  // power-on reset with a fresh configuration word
  task automatic por(input logic dp, input logic pp, input logic [1:0] wrt);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    cfg_dp <= dp;
    cfg_pp <= pp;
    cfg_wrt <= wrt;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
  endtask : por

  // bounded wait for the hold-off to run out
  task automatic wait_hold();
    int n;
    for (n = 0; n < HOLD + 100 && holdoff_act !== 1'b0; n++) @(posedge clk_sys_i);
    chk("holdoff end", 32'h0, {31'h0, holdoff_act});
  endtask : wait_hold

  // drive the external pins, check the gating, release
  task automatic ext(input logic [2:0] p, input logic g, input string nm);
    @(posedge clk_sys_i);
    ext_pins <= p;
    settle(8);
    chk({nm, " grant"}, {31'h0, g}, {31'h0, ext_grant});
    chk({nm, " deny"}, {31'h0, ~g}, {31'h0, ext_deny});
    @(posedge clk_sys_i);
    ext_pins <= 3'b000;
    settle(8);
  endtask : ext

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask : test_end

  // verdict, the one place where the run ends
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // main sequence: data protection phase, then program protection phase
  initial begin
    {resetn_i, warm_reset_i, wb_cyc_i, wb_stb_i, wb_we_i, mem_done} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, mem_rdata, ext_pins} = '0;
    {cfg_dp, cfg_pp, cfg_wrt} = 4'hF;
    ridx = '{NVG_IDX_DATA_LO, NVG_IDX_ADDR_LO, NVG_IDX_DATA_HI, NVG_IDX_ADDR_HI};
    rmsk = '{8'hFF, 8'hFF, 8'h3F, 8'h07};
    por(1'b1, 1'b0, 2'b11);
    settle(0);
    chk("holdoff start", 32'h1, {31'h0, holdoff_act});
    rd("ctrl after power-up", NVG_IDX_CTRL, 8'h00);
    wr(NVG_IDX_CTRL, 8'h04);
    unl();
    wr(NVG_IDX_CTRL, 8'h06);
    settle(1);
    chk("req in hold-off", 32'h0, {31'h0, mem_cmd.req});
    rd("ctrl in hold-off", NVG_IDX_CTRL, 8'h04);
    wait_hold();
    test_end("hold-off");
    for (int i = 0; i < 4; i++) begin
      rval[i] = 8'(rnd());
      wr(ridx[i], rval[i]);
    end
    for (int i = 0; i < 4; i++) rd("reg readback", ridx[i], rval[i] & rmsk[i]);
    wr(NVG_IDX_UNLOCK, 8'h5A);
    rd("unlock port", NVG_IDX_UNLOCK, 8'h00);
    rd("unmapped", 10'h3FF, 8'h00);
    test_end("registers");
    wr(NVG_IDX_CTRL, 8'h06);
    settle(1);
    chk("req without unlock", 32'h0, {31'h0, mem_cmd.req});
    wr(NVG_IDX_CTRL, 8'h00);
    unl();
    wr(NVG_IDX_CTRL, 8'h02);
    settle(1);
    chk("req without permit", 32'h0, {31'h0, mem_cmd.req});
    rd("ctrl refused", NVG_IDX_CTRL, 8'h00);
    test_end("refused starts");
    wr(NVG_IDX_IRQ_EN2, 8'h10);
    wr(NVG_IDX_CTRL, 8'h04);
    unl();
    wr(NVG_IDX_CTRL, 8'h06);
    settle(1);
    chk("data write req", 32'h1, {31'h0, mem_cmd.req & mem_cmd.we});
    chk("data write addr", {24'h0, rval[1]}, {24'h0, mem_cmd.addr[7:0]});
    chk("data write byte", {24'h0, rval[0]}, {24'h0, mem_cmd.wdata[7:0]});
    rd("ctrl busy", NVG_IDX_CTRL, 8'h06);
    done_pulse(14'(rnd()));
    settle(3);
    chk("irq enabled", 32'h1, {31'h0, irq_o});
    rd("done flag", NVG_IDX_IRQ_FLAGS2, 8'h10);
    rd("ctrl idle", NVG_IDX_CTRL, 8'h04);
    wr(NVG_IDX_IRQ_FLAGS2, 8'h10);
    settle(2);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wr(NVG_IDX_IRQ_EN2, 8'h00);
    unl();
    wr(NVG_IDX_CTRL, 8'h06);
    done_pulse(14'(rnd()));
    settle(3);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd("masked flag", NVG_IDX_IRQ_FLAGS2, 8'h10);
    wr(NVG_IDX_IRQ_FLAGS2, 8'h10);
    wr(NVG_IDX_CTRL, 8'h05);
    settle(1);
    chk("data read req", 32'h1, {31'h0, mem_cmd.req & ~mem_cmd.we});
    md = 14'(rnd());
    done_pulse(md);
    rd("no flag after read", NVG_IDX_IRQ_FLAGS2, 8'h00);
    rd("data read byte", NVG_IDX_DATA_LO, md[7:0]);
    test_end("own data access");
    ext(3'b100, 1'b0, "ext data read");
    ext(3'b111, 1'b0, "ext prog write");
    ext(3'b101, 1'b1, "ext prog read");
    test_end("data protection");
    unl();
    wr(NVG_IDX_CTRL, 8'h06);
    @(posedge clk_sys_i);
    warm_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    warm_reset_i <= 1'b0;
    settle(1);
    chk("req aborted", 32'h0, {31'h0, mem_cmd.req});
    rd("fault after abort", NVG_IDX_CTRL, 8'h08);
    rd("data kept", NVG_IDX_DATA_LO, md[7:0]);
    rd("addr kept", NVG_IDX_ADDR_LO, rval[1]);
    test_end("warm reset");
    por(1'b0, 1'b1, 2'b10);
    wait_hold();
    wr(NVG_IDX_CTRL, 8'h84);
    wr(NVG_IDX_ADDR_HI, 8'h01);
    wr(NVG_IDX_ADDR_LO, 8'h00);
    unl();
    wr(NVG_IDX_CTRL, 8'h86);
    settle(1);
    chk("req protected region", 32'h0, {31'h0, mem_cmd.req});
    rd("ctrl region refused", NVG_IDX_CTRL, 8'h84);
    wr(NVG_IDX_ADDR_HI, 8'h03);
    unl();
    wr(NVG_IDX_CTRL, 8'h96);
    settle(1);
    chk("prog write req", 32'h1, {31'h0, mem_cmd.req & mem_cmd.space});
    chk("prog erase", 32'h1, {31'h0, mem_cmd.erase & mem_cmd.we});
    chk("prog write addr", 32'h300, {21'h0, mem_cmd.addr});
    done_pulse(14'(rnd()));
    wr(NVG_IDX_CTRL, 8'h81);
    settle(1);
    chk("prog read req", 32'h1, {31'h0, mem_cmd.req & ~mem_cmd.we});
    md = 14'(rnd());
    done_pulse(md);
    rd("prog word low", NVG_IDX_DATA_LO, md[7:0]);
    rd("prog word high", NVG_IDX_DATA_HI, {2'b00, md[13:8]});
    test_end("program self access");
    ext(3'b101, 1'b0, "ext prog read");
    ext(3'b100, 1'b1, "ext data read");
    test_end("program protection");
    settle(2);
    complete_run();
  end
endmodule : test_nv_memory_write_guard
